// ===== hre_pkg.sv
// package of constants and the cause byte encoder of the reply record
package hre_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_PROC   = 8'h00; // processing status
   localparam logic [7:0] OFF_REPLY  = 8'h04; // reply bytes 1 and 2
   localparam logic [7:0] OFF_FDSTAT = 8'h08; // field device status bytes
   localparam logic [7:0] OFF_DIAG   = 8'h0C; // channel error byte
   localparam logic [7:0] OFF_CTRL   = 8'h10; // command issue
   localparam logic [7:0] OFF_ISTAT  = 8'h14; // sticky events, write one to clear
   localparam logic [7:0] OFF_IMASK  = 8'h18; // event mask
   // ==========================================================
   // processing status codes
   localparam logic [2:0] PS_INACTIVE  = 3'h0;
   localparam logic [2:0] PS_RESERVED  = 3'h1;
   localparam logic [2:0] PS_WAITING   = 3'h2;
   localparam logic [2:0] PS_EXECUTING = 3'h3;
   localparam logic [2:0] PS_OK_DATA   = 3'h4;
   localparam logic [2:0] PS_OK_NODATA = 3'h5;
   localparam logic [2:0] PS_ERR_DATA  = 3'h6;
   localparam logic [2:0] PS_ERR_NODATA = 3'h7;
   // ==========================================================
   // reply byte 1 field positions
   localparam int B1_MORE_STATUS = 0;
   localparam int B1_COMM_ERROR  = 1;
   localparam int B1_PARAM_CHECK = 2;
   localparam int B1_RESERVED    = 3;
   localparam int B1_CAT_LSB     = 4;
   // channel error byte: more status bit and comm error bit
   localparam int DIAG_MORE_STATUS = 4;
   localparam int DIAG_COMM_ERROR  = 0;
   // ==========================================================
   // error categories
   localparam logic [3:0] CAT_UNSPEC   = 4'h0;
   localparam logic [3:0] CAT_MODEM    = 4'h1;
   localparam logic [3:0] CAT_CHANNEL  = 4'h2;
   localparam logic [3:0] CAT_COMMAND  = 4'h3;
   localparam logic [3:0] CAT_QUERY    = 4'h4;
   localparam logic [3:0] CAT_REPLY    = 4'h5;
   localparam logic [3:0] CAT_REJECT   = 4'h6;
   localparam logic [3:0] CAT_PROFILE  = 4'h7;
   localparam logic [3:0] CAT_VENDOR   = 4'h8;
   // highest legal cause codes of the enumerated categories
   localparam logic [2:0] MAX_MODEM_CAUSE   = 3'h5;
   localparam logic [2:0] MAX_CHANNEL_CAUSE = 3'h5;
   localparam logic [2:0] MAX_REJECT_CAUSE  = 3'h4;
   // flag masks of the query and reply categories, bit 7 set
   localparam logic [7:0] QUERY_FLAG_MASK = 8'h7A;
   localparam logic [7:0] REPLY_FLAG_MASK = 8'h7F;
   localparam logic [7:0] PROTO_FLAG_BIT  = 8'h80;
   // ==========================================================
   // control and event bits
   localparam int CTRL_ISSUE  = 0;
   localparam int EV_OK       = 0;
   localparam int EV_FAULT    = 1;
   localparam int EV_PARAM    = 2;
   localparam int EV_WIDTH    = 3;
   localparam logic [2:0] IMASK_RESET = 3'h0;
endpackage

`timescale 1ns/10ps

// ==========================================================
// cause byte: meaning depends on the error category
module hre_cause_encoder
(
   input  wire logic [3:0] category,
   input  wire logic [2:0] modem_cause,
   input  wire logic [2:0] channel_cause,
   input  wire logic [6:0] response_code,
   input  wire logic [6:0] rx_flags,
   input  wire logic [2:0] reject_cause,
   output logic      [7:0] cause_byte
);
   // out of range enumerated causes collapse to unspecified
   function automatic logic [7:0] limit_code(input logic [2:0] code, input logic [2:0] top);
      limit_code = (code <= top) ? {5'h00, code} : 8'h00;
   endfunction

   // select the cause layout of the category
   always_comb
   begin
      case (category)
         hre_pkg::CAT_MODEM:   cause_byte = limit_code(modem_cause, hre_pkg::MAX_MODEM_CAUSE);
         hre_pkg::CAT_CHANNEL: cause_byte = limit_code(channel_cause,
                                                       hre_pkg::MAX_CHANNEL_CAUSE);
         hre_pkg::CAT_COMMAND: cause_byte = {1'b0, response_code};
         hre_pkg::CAT_QUERY:   cause_byte = hre_pkg::PROTO_FLAG_BIT
                                          | ({1'b0, rx_flags} & hre_pkg::QUERY_FLAG_MASK);
         hre_pkg::CAT_REPLY:   cause_byte = hre_pkg::PROTO_FLAG_BIT
                                          | ({1'b0, rx_flags} & hre_pkg::REPLY_FLAG_MASK);
         hre_pkg::CAT_REJECT:  cause_byte = limit_code(reject_cause,
                                                       hre_pkg::MAX_REJECT_CAUSE);
         default:              cause_byte = 8'h00;
      endcase
   end
endmodule // hre_cause_encoder

// ===== hre_reply_encoder.sv
// reply record fault encoder with apb register access
`timescale 1ns/10ps

module hre_reply_encoder
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        chan_exec,
   input  wire logic        chan_done,
   input  wire logic        chan_fault,
   input  wire logic        chan_with_data,
   input  wire logic [3:0]  chan_category,
   input  wire logic [2:0]  modem_cause,
   input  wire logic [2:0]  channel_cause,
   input  wire logic [6:0]  response_code,
   input  wire logic [6:0]  rx_flags,
   input  wire logic [2:0]  reject_cause,
   input  wire logic [7:0]  fd_status1,
   input  wire logic [7:0]  fd_status2,
   input  wire logic        fd_comm_error,
   input  wire logic        loop_modem_changed,
   output logic             cmd_issue,
   output logic [2:0]       proc_status,
   output logic [7:0]       reply_byte1,
   output logic [7:0]       reply_byte2,
   output logic             irq
);
   // ==========================================================
   // state
   typedef enum logic [2:0]
   {
      HRE_IDLE = 3'b001,
      HRE_WAIT = 3'b010,
      HRE_EXEC = 3'b100
   } hre_phase_type;

   typedef struct packed
   {
      hre_phase_type phase;
      logic [2:0]    proc_status;
      logic [7:0]    byte1;
      logic [7:0]    byte2;
      logic [7:0]    stat1;
      logic [7:0]    stat2;
      logic [7:0]    diag;
      logic [2:0]    ev;
      logic [2:0]    mask;
      logic [31:0]   prdata;
      logic          pready;
      logic          pslverr;
      logic          cmd_issue;
      logic          irq;
   } hre_state_type;

   hre_state_type r;
   hre_state_type next_r;
   logic [7:0]    cause_byte;
   logic          access;
   logic          done_now;

   // ==========================================================
   // cause byte of the current outcome
   hre_cause_encoder u_cause
   (
      .category      (chan_category),
      .modem_cause   (modem_cause),
      .channel_cause (channel_cause),
      .response_code (response_code),
      .rx_flags      (rx_flags),
      .reject_cause  (reject_cause),
      .cause_byte    (cause_byte)
   );

   // read word of an address, error flag for unmapped ones
   function automatic logic [32:0] read_word(input hre_state_type s, input logic [7:0] a);
      case (a)
         hre_pkg::OFF_PROC:   read_word = {1'b0, 29'h0, s.proc_status};
         hre_pkg::OFF_REPLY:  read_word = {1'b0, 16'h0, s.byte2, s.byte1};
         hre_pkg::OFF_FDSTAT: read_word = {1'b0, 16'h0, s.stat2, s.stat1};
         hre_pkg::OFF_DIAG:   read_word = {1'b0, 24'h0, s.diag};
         hre_pkg::OFF_CTRL:   read_word = {1'b0, 32'h0};
         hre_pkg::OFF_ISTAT:  read_word = {1'b0, 29'h0, s.ev};
         hre_pkg::OFF_IMASK:  read_word = {1'b0, 29'h0, s.mask};
         default:             read_word = {1'b1, 32'h0};
      endcase
   endfunction

   assign access   = psel & penable & r.pready;
   assign done_now = chan_done & (r.phase != HRE_IDLE);

   // ==========================================================
   // next state
   always_comb
   begin
      logic [32:0] rd;
      logic [2:0]  set_ev;
      rd     = read_word(r, paddr);
      set_ev = '0;
      next_r = r;
      next_r.cmd_issue = 1'b0;
      // apb: setup cycle prepares the answer, access cycle completes it
      next_r.pready  = psel & ~penable;
      next_r.pslverr = psel & ~penable & rd[32];
      next_r.prdata  = (psel & ~penable & ~pwrite) ? rd[31:0] : 32'h0;
      // command issue starts a wait unless one is in flight
      if (access && pwrite && paddr == hre_pkg::OFF_CTRL && pwdata[hre_pkg::CTRL_ISSUE]
          && r.phase == HRE_IDLE)
      begin
         next_r.phase       = HRE_WAIT;
         next_r.proc_status = hre_pkg::PS_WAITING;
         next_r.cmd_issue   = 1'b1;
      end
      if (access && pwrite && paddr == hre_pkg::OFF_IMASK)
      begin
         next_r.mask = pwdata[hre_pkg::EV_WIDTH-1:0];
      end
      // channel side progress
      if (chan_exec && r.phase == HRE_WAIT && !chan_done)
      begin
         next_r.phase       = HRE_EXEC;
         next_r.proc_status = hre_pkg::PS_EXECUTING;
      end
      if (done_now)
      begin
         next_r.phase = HRE_IDLE;
         next_r.stat1 = fd_status1;
         next_r.stat2 = fd_status2;
         next_r.diag  = 8'h00;
         next_r.diag[hre_pkg::DIAG_MORE_STATUS] = |fd_status2;
         next_r.diag[hre_pkg::DIAG_COMM_ERROR]  = chan_fault & fd_comm_error;
         if (chan_fault)
         begin
            // record and status change together
            next_r.proc_status = chan_with_data ? hre_pkg::PS_ERR_DATA
                                                : hre_pkg::PS_ERR_NODATA;
            next_r.byte1 = 8'h00;
            next_r.byte1[hre_pkg::B1_MORE_STATUS] = |fd_status2;
            next_r.byte1[hre_pkg::B1_COMM_ERROR]  = fd_comm_error;
            next_r.byte1[hre_pkg::B1_PARAM_CHECK] = loop_modem_changed;
            next_r.byte1[hre_pkg::B1_RESERVED]    = 1'b0;
            next_r.byte1[hre_pkg::B1_CAT_LSB +: 4] = chan_category;
            next_r.byte2 = cause_byte;
            set_ev[hre_pkg::EV_FAULT] = 1'b1;
            set_ev[hre_pkg::EV_PARAM] = loop_modem_changed;
         end
         else
         begin
            next_r.proc_status = chan_with_data ? hre_pkg::PS_OK_DATA
                                                : hre_pkg::PS_OK_NODATA;
            next_r.byte1 = 8'h00;
            next_r.byte2 = 8'h00;
            set_ev[hre_pkg::EV_OK] = 1'b1;
         end
      end
      // sticky events: write one clears, a new event wins
      if (access && pwrite && paddr == hre_pkg::OFF_ISTAT)
      begin
         next_r.ev = r.ev & ~pwdata[hre_pkg::EV_WIDTH-1:0];
      end
      next_r.ev  = next_r.ev | set_ev;
      next_r.irq = |(next_r.ev & next_r.mask);
   end

   // ==========================================================
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r             <= '0;
         r.phase       <= HRE_IDLE;
         r.proc_status <= hre_pkg::PS_INACTIVE;
         r.mask        <= hre_pkg::IMASK_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign prdata      = r.prdata;
   assign pready      = r.pready;
   assign pslverr     = r.pslverr;
   assign cmd_issue   = r.cmd_issue;
   assign proc_status = r.proc_status;
   assign reply_byte1 = r.byte1;
   assign reply_byte2 = r.byte2;
   assign irq         = r.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_done_record: assert property (done_now && chan_fault |=>
         proc_status[2:1] == 2'b11 && reply_byte1[7:4] == $past(chan_category))
      else $error("fault completion did not load the record");
   chk_status_code: assert property (done_now |=>
         proc_status == {1'b1, $past(chan_fault), ~$past(chan_with_data)})
      else $error("processing status code wrong at completion");
   chk_more_status: assert property (done_now && chan_fault |=>
         reply_byte1[0] == r.diag[4] && r.diag[4] == |$past(fd_status2))
      else $error("more status bit does not mirror the error byte");
   chk_comm_error: assert property (done_now && chan_fault |=>
         reply_byte1[1] == $past(fd_comm_error) && r.stat1 == $past(fd_status1))
      else $error("comm error bit or status byte 1 wrong");
   chk_reserved_bit: assert property (reply_byte1[3] == 1'b0)
      else $error("reserved bit of byte 1 set");
   chk_param_check: assert property (done_now && chan_fault |=>
         reply_byte1[2] == $past(loop_modem_changed))
      else $error("parameter check bit wrong");
   chk_category: assert property (done_now && chan_fault |=>
         reply_byte1[7:4] == $past(chan_category) ##1 $stable(reply_byte1) [*2])
      else $error("category field not held");
   chk_modem_cause: assert property (done_now && chan_fault && chan_category == 4'h1 |=>
         reply_byte2 == ($past(modem_cause) <= 3'h5 ? {5'h00, $past(modem_cause)} : 8'h00))
      else $error("modem cause byte wrong");
   chk_channel_cause: assert property (done_now && chan_fault && chan_category == 4'h2 |=>
         reply_byte2 <= 8'h05)
      else $error("channel cause out of range");
   chk_proto_bit: assert property (done_now && chan_fault |=>
         reply_byte2[7] == ($past(chan_category) == 4'h4 || $past(chan_category) == 4'h5))
      else $error("protocol flag bit of byte 2 wrong");
   chk_query_resv: assert property (done_now && chan_fault && chan_category == 4'h4 |=>
         reply_byte2[0] == 1'b0 && reply_byte2[2] == 1'b0)
      else $error("query reserved bits set");
   chk_reply_flags: assert property (done_now && chan_fault && chan_category == 4'h5 |=>
         reply_byte2 == {1'b1, $past(rx_flags)})
      else $error("reply flags not passed");
   chk_reject_cause: assert property (done_now && chan_fault && chan_category == 4'h6 |=>
         reply_byte2 <= 8'h04)
      else $error("reject reason out of range");
   chk_zero_cause: assert property (done_now && chan_fault && (chan_category == 4'h0 ||
         chan_category >= 4'h7) |=> reply_byte2 == 8'h00)
      else $error("cause byte not zero");
   chk_clean_ok: assert property (done_now && !chan_fault |=>
         reply_byte1 == 8'h00 && reply_byte2 == 8'h00 && proc_status[1] == 1'b0)
      else $error("stale fault shown after clean completion");

   // ==========================================================
   // checks of the bus answer and the status sequence
   chk_ready_pulse: assert property (psel && !penable |=> pready)
      else $error("no ready in the access cycle");
   chk_ready_drop: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   chk_error_read: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer without ready or with data");
   chk_issue_wait: assert property (cmd_issue |-> proc_status == hre_pkg::PS_WAITING)
      else $error("issued command not shown as waiting");
   chk_issue_pulse: assert property (cmd_issue |=> !cmd_issue)
      else $error("issue pulse stood longer than one cycle");
   chk_exec_step: assert property (chan_exec && r.phase == HRE_WAIT && !chan_done |=>
         proc_status == hre_pkg::PS_EXECUTING)
      else $error("executing status not shown");
   chk_status_copy: assert property (done_now |=> r.stat1 == $past(fd_status1) &&
         r.stat2 == $past(fd_status2))
      else $error("status bytes not captured unchanged");
   chk_fault_event: assert property (done_now && chan_fault |=> r.ev[1] == 1'b1)
      else $error("fault event not recorded");
   chk_ok_event: assert property (done_now && !chan_fault |=> r.ev[0] == 1'b1)
      else $error("success event not recorded");
   chk_irq_fault: assert property (done_now && chan_fault && r.mask[1] |=> irq)
      else $error("unmasked fault event gave no interrupt");

   // ==========================================================
   // checks of the cause byte per category
   chk_command_code: assert property (done_now && chan_fault && chan_category == 4'h3
         |=> reply_byte2 == {1'b0, $past(response_code)})
      else $error("command response code wrong");
   chk_query_flags: assert property (done_now && chan_fault && chan_category == 4'h4
         |=> reply_byte2 == (8'h80 | ({1'b0, $past(rx_flags)} & 8'h7A)))
      else $error("query flags wrong");
   chk_channel_code: assert property (done_now && chan_fault && chan_category == 4'h2
         |=> reply_byte2 == ($past(channel_cause) <= 3'h5 ? {5'h00, $past(channel_cause)}
                                                           : 8'h00))
      else $error("channel cause byte wrong");
   chk_reject_code: assert property (done_now && chan_fault && chan_category == 4'h6
         |=> reply_byte2 == ($past(reject_cause) <= 3'h4 ? {5'h00, $past(reject_cause)}
                                                         : 8'h00))
      else $error("reject reason byte wrong");
endmodule // hre_reply_encoder

// ===== hre_field_dev.sv
// far-side field device model answering each issued command
`timescale 1ns/10ps

module hre_field_dev
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        cmd_issue,
   input  wire logic        slow,
   input  wire logic [46:0] plan,
   output logic             chan_exec,
   output logic             chan_done,
   output logic [46:0]      resp
);
   int cnt;

   // ==========================================================
   // answer countdown: prompt reply, or slow reply with an execute step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt       <= 0;
         chan_exec <= 1'h0;
         chan_done <= 1'h0;
      end
      else
      begin
         chan_exec <= (cnt == 4);
         chan_done <= (cnt == 1);
         if (cmd_issue)
            cnt <= slow ? 8 : 2;
         else if (cnt > 0)
            cnt <= cnt - 1;
      end
   end

   // reply fields mean nothing outside the done pulse
   assign resp = chan_done ? plan : ~plan;
endmodule // hre_field_dev

// ===== test_hre_reply_encoder.sv
// self-checking bench of the reply record fault encoder
`timescale 1ns/10ps

`define CHK(got, exp) \
begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_hre_reply_encoder;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, chan_exec, chan_done, cmd_issue, irq, er;
   logic        slow = 1'h0;
   logic [2:0]  proc_status, code;
   logic [3:0]  cat;
   logic [7:0]  reply_byte1, reply_byte2;
   logic [46:0] plan = 47'h0, resp;
   int          bad_count = 0;
   int          samples_checked = 0;

   always #2.5 pclk = ~pclk;

   hre_reply_encoder u_dut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .chan_exec, .chan_done, .chan_fault(resp[46]), .chan_with_data(resp[45]),
      .chan_category(resp[44:41]), .modem_cause(resp[40:38]), .channel_cause(resp[37:35]),
      .response_code(resp[34:28]), .rx_flags(resp[27:21]), .reject_cause(resp[20:18]),
      .fd_status1(resp[17:10]), .fd_status2(resp[9:2]), .fd_comm_error(resp[1]),
      .loop_modem_changed(resp[0]), .cmd_issue, .proc_status, .reply_byte1, .reply_byte2, .irq
   );

   hre_field_dev u_dev (.pclk, .presetn, .cmd_issue, .slow, .plan, .chan_exec, .chan_done, .resp);

   // ==========================================================
   // one apb transfer, waiting for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   // expected cause byte for a faulty reply
   function automatic logic [7:0] exp_b2(input logic [46:0] p);
      case (p[44:41])
         4'h1: exp_b2 = (p[40:38] <= 3'h5) ? {5'h00, p[40:38]} : 8'h00;
         4'h2: exp_b2 = (p[37:35] <= 3'h5) ? {5'h00, p[37:35]} : 8'h00;
         4'h3: exp_b2 = {1'h0, p[34:28]};
         4'h4: exp_b2 = {1'h1, p[27:21] & 7'h7A};
         4'h5: exp_b2 = {1'h1, p[27:21]};
         4'h6: exp_b2 = (p[20:18] <= 3'h4) ? {5'h00, p[20:18]} : 8'h00;
         default: exp_b2 = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // issue a command, let the device answer, judge the record
   task automatic run_txn(input logic [46:0] p, input logic sl);
      logic [7:0] b1, b2;
      logic       seen;
      int         n;
      b2 = p[46] ? exp_b2(p) : 8'h00;
      b1 = p[46] ? {p[44:41], 1'h0, p[0], p[1], |p[9:2]} : 8'h00;
      plan <= p;
      slow <= sl;
      apb(1'h1, hre_pkg::OFF_CTRL, 32'h1, rd, er);
      @(posedge pclk);
      `CHK(proc_status, hre_pkg::PS_WAITING)
      seen = 1'h0;
      n = 0;
      while (proc_status[2] !== 1'h1 && n < 40)
      begin
         @(posedge pclk);
         seen |= (proc_status === hre_pkg::PS_EXECUTING);
         n++;
      end
      if (n >= 40)
      begin
         bad_count++;
         final_report();
      end
      `CHK(seen, sl)
      `CHK(proc_status, {1'h1, p[46], ~p[45]})
      `CHK(reply_byte1, b1)
      `CHK(reply_byte2, b2)
      apb(1'h0, hre_pkg::OFF_REPLY, 32'h0, rd, er);
      `CHK(rd, {16'h0000, b2, b1})
      apb(1'h0, hre_pkg::OFF_FDSTAT, 32'h0, rd, er);
      `CHK(rd, {16'h0000, p[9:2], p[17:10]})
   endtask

   // reset values and an unmapped address
   task automatic check_reset();
      `CHK({proc_status, reply_byte1, reply_byte2, irq}, 20'h0)
      apb(1'h0, hre_pkg::OFF_IMASK, 32'h0, rd, er);
      `CHK(rd, 32'h0)
      apb(1'h0, 8'hFC, 32'h0, rd, er);
      `CHK({er, rd}, 33'h100000000)
   endtask

   // old events cleared, fault raises irq, write one clears, masked ok stays quiet
   task automatic irq_flow();
      apb(1'h1, hre_pkg::OFF_ISTAT, 32'h7, rd, er);
      apb(1'h1, hre_pkg::OFF_IMASK, 32'h2, rd, er);
      `CHK(irq, 1'h0)
      run_txn({2'h2, 4'h5, 23'h7F, 16'h0, 2'h0}, 1'h0);
      `CHK(irq, 1'h1)
      apb(1'h0, hre_pkg::OFF_ISTAT, 32'h0, rd, er);
      `CHK(rd, 32'h2)
      apb(1'h1, hre_pkg::OFF_ISTAT, 32'h7, rd, er);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'h0)
      apb(1'h1, hre_pkg::OFF_IMASK, 32'h0, rd, er);
      run_txn({2'h0, 4'h0, 23'h0, 16'h0, 2'h0}, 1'h0);
      `CHK(irq, 1'h0)
      apb(1'h0, hre_pkg::OFF_ISTAT, 32'h0, rd, er);
      `CHK(rd, 32'h1)
      apb(1'h1, hre_pkg::OFF_IMASK, 32'h1, rd, er);
      `CHK(irq, 1'h1)
   endtask

   task automatic final_report();
      if (bad_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==========================================================
   // main sequence: every category with every cause code, then clean and irq
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      check_reset();
      for (int j = 0; j < 80; j++)
      begin
         cat = 4'(j % 10);
         code = 3'(j / 10);
         run_txn({1'h1, code[0], cat, code, ~code, {code, 4'h9}, {code, ~code, code[0]}, code ^ 3'h5,
                  8'hA0 | {5'h00, code}, {1'h0, code[1], 6'h00}, code[2], j[0]}, (j % 3) == 0);
      end
      run_txn({2'h0, 4'h3, 23'h0, 8'h11, 8'h22, 2'h3}, 1'h1);
      irq_flow();
      final_report();
   end
endmodule // test_hre_reply_encoder
